// *** rtl/lps_consts.svh ***
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH
// Clock period in ns (125 MHz)
`define LPS_CLK_NS           8
// Protection intervals in us, all plain defaults
`define LPS_OVC_STOP_US      50
`define LPS_SURGE_TIMEOUT_US 100
`define LPS_BRN_QUAL_US      50
`define LPS_OPT_QUAL_US      100
`define LPS_DIS_QUAL_US      20
`define LPS_REC_US           1000
`define LPS_SOFT_START_US    200
// Cycle counts: least times round up
`define LPS_US2CYC(us)       ((((us) * 1000) + `LPS_CLK_NS - 1) / `LPS_CLK_NS)
`define LPS_OVC_STOP_CYC     `LPS_US2CYC(`LPS_OVC_STOP_US)
`define LPS_SURGE_TO_CYC     `LPS_US2CYC(`LPS_SURGE_TIMEOUT_US)
`define LPS_BRN_QUAL_CYC     `LPS_US2CYC(`LPS_BRN_QUAL_US)
`define LPS_OPT_QUAL_CYC     `LPS_US2CYC(`LPS_OPT_QUAL_US)
`define LPS_DIS_QUAL_CYC     `LPS_US2CYC(`LPS_DIS_QUAL_US)
`define LPS_REC_CYC          `LPS_US2CYC(`LPS_REC_US)
`define LPS_SS_CYC           `LPS_US2CYC(`LPS_SOFT_START_US)
`endif

// *** rtl/lps_pkg.sv ***
package lps_pkg;
  // Operating state, Gray along soft->active->stop->surge->lowc path
  typedef enum logic [2:0] {
    LPS_S_SOFT  = 3'h0,
    LPS_S_ACT   = 3'h1,
    LPS_S_STOP  = 3'h3,
    LPS_S_SURGE = 3'h2,
    LPS_S_LOWC  = 3'h6
  } lps_state_t;
  // Why low consumption was entered
  typedef enum logic [1:0] {
    LPS_LC_TIMED = 2'h0,
    LPS_LC_SURGE = 2'h1,
    LPS_LC_CTRL  = 2'h2
  } lps_lc_cause_t;
  // Fault detector outputs
  typedef struct packed {
    logic overcurrent;
    logic surge_high;
    logic surge_safe;
    logic brownout;
    logic opto_fault;
    logic out_overvolt;
    logic ctrl_low;
    logic ctrl_high;
  } lps_faults_t;
  // Sequencer outputs
  typedef struct packed {
    logic gate_enable;
    logic hv_startup_on;
    logic ss_discharge;
    logic fb_extra_sink;
    logic soft_start_run;
  } lps_ctrl_t;
endpackage : lps_pkg

// *** rtl/lps_sequencer.sv ***
`timescale 1ns/1ns
`include "lps_consts.svh"
// Summary of operation
// - Overcurrent: gate off, stop timed interval
// - Surge above threshold halts switching immediately
// - Short surge: resume directly, no startup
// - Long surge: low consumption until safe
// - After long surge, full startup procedure
// - Qualified brownout: stop recovery time, restart
// - Brownout checked only active, masked soft-start
// - Qualified optocoupler fault: enter low consumption
// - Timer measures fault, restarts after recovery
// - Optocoupler check active only, masked soft-start
// - Output overvoltage drives extra feedback sink while active
// - Control low: low consumption; release: soft-start
// - Qualified control high: low consumption, auto-restart
// - Low consumption entry resets soft-start
// - Startup source on only in low consumption
module lps_sequencer
  import lps_pkg::*;
#(
  parameter int unsigned TW        = 20,
  parameter int unsigned OVC_CYC   = `LPS_OVC_STOP_CYC,
  parameter int unsigned SURGE_CYC = `LPS_SURGE_TO_CYC,
  parameter int unsigned BRN_CYC   = `LPS_BRN_QUAL_CYC,
  parameter int unsigned OPT_CYC   = `LPS_OPT_QUAL_CYC,
  parameter int unsigned DIS_CYC   = `LPS_DIS_QUAL_CYC,
  parameter int unsigned REC_CYC   = `LPS_REC_CYC,
  parameter int unsigned SS_CYC    = `LPS_SS_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire lps_faults_t faults,
  output lps_ctrl_t        ctrl,
  output lps_state_t       state
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser
  logic rst_meta_q;   // First stage, read only by second
  logic rst_sync_q;   // Released reset, active low: 1 once released
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rstn_i = rst_sync_q;  // Internal reset, active low

  ////////////////////////////////////////////////////////////////////////////
  // Operating state, declared early: the counters below decode it
  lps_state_t    state_q, state_d;   // Operating state

  ////////////////////////////////////////////////////////////////////////////
  // Fault qualification counters (auto_restart_timer side)
  // Each counter saturates at its limit, so a long fault cannot wrap
  // round and drop a trip that is already pending.
  logic [TW-1:0] brn_cnt_q, brn_cnt_d;  // Brownout duration
  logic [TW-1:0] opt_cnt_q, opt_cnt_d;  // Optocoupler fault duration
  logic [TW-1:0] dis_cnt_q, dis_cnt_d;  // High disable duration
  logic          brn_trip, opt_trip, dis_trip;

  // Counters run only where the check is live
  always_comb begin
    brn_cnt_d = '0;
    opt_cnt_d = '0;
    dis_cnt_d = '0;
    if (state_q == LPS_S_ACT && faults.brownout) begin
      brn_cnt_d = (brn_cnt_q == TW'(BRN_CYC)) ? brn_cnt_q : brn_cnt_q + TW'(1);
    end
    if (state_q == LPS_S_ACT && faults.opto_fault) begin
      opt_cnt_d = (opt_cnt_q == TW'(OPT_CYC)) ? opt_cnt_q : opt_cnt_q + TW'(1);
    end
    // Hazard: disable qualified in any running state, not only active
    if (state_q != LPS_S_LOWC && faults.ctrl_high) begin
      dis_cnt_d = (dis_cnt_q == TW'(DIS_CYC)) ? dis_cnt_q : dis_cnt_q + TW'(1);
    end
  end
  // Trip once held for the full qualify time
  assign brn_trip = (brn_cnt_q == TW'(BRN_CYC));
  assign opt_trip = (opt_cnt_q == TW'(OPT_CYC));
  assign dis_trip = (dis_cnt_q == TW'(DIS_CYC));

  // Register qualification counters
  always_ff @(posedge sys_clk or negedge rstn_i) begin
    if (!rstn_i) begin
      brn_cnt_q <= '0;
      opt_cnt_q <= '0;
      dis_cnt_q <= '0;
    end else begin
      brn_cnt_q <= brn_cnt_d;
      opt_cnt_q <= opt_cnt_d;
      dis_cnt_q <= dis_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer and interval timer
  // One timer serves every interval; only one interval can be live at a
  // time, which saves three counters at the cost of reloading on entry.
  lps_lc_cause_t cause_q, cause_d;   // Reason for low consumption
  logic [TW-1:0] tmr_q, tmr_d;       // Shared interval timer
  logic          tmr_done;           // Current interval expired
  lps_ctrl_t     ctrl_q, ctrl_d;     // Registered outputs

  assign tmr_done = (tmr_q == '0);

  // Next state: low consumption requests checked first
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    tmr_d   = tmr_done ? tmr_q : tmr_q - TW'(1);
    if (state_q != LPS_S_LOWC && faults.ctrl_low) begin
      state_d = LPS_S_LOWC;
      cause_d = LPS_LC_CTRL;
      tmr_d   = '0;
    end else if (state_q != LPS_S_LOWC && (dis_trip || opt_trip)) begin
      state_d = LPS_S_LOWC;
      cause_d = LPS_LC_TIMED;
      tmr_d   = TW'(REC_CYC);
    end else begin
      unique case (state_q)
        LPS_S_SOFT: begin
          // Soft-start ends into active switching
          if (faults.surge_high) begin
            state_d = LPS_S_SURGE;
            tmr_d   = TW'(SURGE_CYC);
          end else if (faults.overcurrent) begin
            state_d = LPS_S_STOP;
            tmr_d   = TW'(OVC_CYC);
          end else if (tmr_done) begin
            state_d = LPS_S_ACT;
          end
        end
        LPS_S_ACT: begin
          // Surge first, then overcurrent, then brownout
          if (faults.surge_high) begin
            state_d = LPS_S_SURGE;
            tmr_d   = TW'(SURGE_CYC);
          end else if (faults.overcurrent) begin
            state_d = LPS_S_STOP;
            tmr_d   = TW'(OVC_CYC);
          end else if (brn_trip) begin
            state_d = LPS_S_STOP;
            tmr_d   = TW'(REC_CYC);
          end
        end
        LPS_S_STOP: begin
          // Timed stop resumes switching directly
          if (faults.surge_high) begin
            state_d = LPS_S_SURGE;
            tmr_d   = TW'(SURGE_CYC);
          end else if (tmr_done) begin
            state_d = LPS_S_ACT;
          end
        end
        LPS_S_SURGE: begin
          // Short surge resumes, long one parks
          if (!faults.surge_high) begin
            state_d = LPS_S_ACT;
          end else if (tmr_done) begin
            state_d = LPS_S_LOWC;
            cause_d = LPS_LC_SURGE;
          end
        end
        LPS_S_LOWC: begin
          // Leave once the entering cause has gone, or for timed causes once the recovery time has run out
          // A held control-low pin keeps every cause parked, so the block
          // never bounces through soft-start for a single cycle.
          unique case (cause_q)
            LPS_LC_CTRL: if (!faults.ctrl_low) begin
              state_d = LPS_S_SOFT;
              tmr_d   = TW'(SS_CYC);
            end
            LPS_LC_SURGE: if (faults.surge_safe && !faults.ctrl_low) begin
              state_d = LPS_S_SOFT;
              tmr_d   = TW'(SS_CYC);
            end
            default: if (tmr_done && !faults.ctrl_low) begin
              state_d = LPS_S_SOFT;
              tmr_d   = TW'(SS_CYC);
            end
          endcase
        end
        default: begin
          // Illegal code: park safely with the gate off
          state_d = LPS_S_LOWC;
          cause_d = LPS_LC_TIMED;
          tmr_d   = TW'(REC_CYC);
        end
      endcase
    end
  end

  // Outputs decoded from the next state so they leave flops
  always_comb begin
    ctrl_d.gate_enable    = (state_d == LPS_S_ACT) || (state_d == LPS_S_SOFT);
    ctrl_d.hv_startup_on  = (state_d == LPS_S_LOWC);
    ctrl_d.ss_discharge   = (state_d == LPS_S_LOWC);
    ctrl_d.soft_start_run = (state_d == LPS_S_SOFT);
    // Extra sink only driven in active switching, not in soft-start
    ctrl_d.fb_extra_sink  = faults.out_overvolt && (state_d == LPS_S_ACT);
  end

  // Register sequencer state; reset parks in low consumption
  always_ff @(posedge sys_clk or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= LPS_S_LOWC;
      cause_q <= LPS_LC_TIMED;
      tmr_q   <= '0;
      ctrl_q  <= '{gate_enable: 1'b0, hv_startup_on: 1'b1, ss_discharge: 1'b1,
                   fb_extra_sink: 1'b0, soft_start_run: 1'b0};
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      tmr_q   <= tmr_d;
      ctrl_q  <= ctrl_d;
    end
  end

  assign ctrl  = ctrl_q;
  assign state = state_q;

endmodule : lps_sequencer

// *** tb/lps_sense_model.sv ***
`timescale 1ns/1ns
module lps_sense_model
  import lps_pkg::*;
(
  input  wire lps_faults_t req,
  output lps_faults_t      faults
);
  ////////////////////////////////////////////////////////////
  // Sensor levels, kept physically consistent
  always_comb begin
    faults            = req;
    // Safe flag can never coexist with surge
    faults.surge_safe = req.surge_safe & ~req.surge_high;
    // One pin cannot be low and high at once
    faults.ctrl_high  = req.ctrl_high & ~req.ctrl_low;
  end
endmodule : lps_sense_model

// *** tb/lps_seq_asserts.sv ***
`timescale 1ns/1ns
module lps_seq_asserts
  import lps_pkg::*;
#(
  parameter int unsigned OVC_CYC = 4,
  parameter int unsigned REC_CYC = 10,
  parameter int unsigned SS_CYC  = 6
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire lps_faults_t faults,
  input wire lps_ctrl_t   ctrl,
  input wire lps_state_t  state
);
  lps_state_t  prev_q; // State one cycle back
  logic [15:0] run_q;  // Length of the run that just ended
  wire quiet = !faults.ctrl_low && !faults.ctrl_high && !faults.surge_high;
  ////////////////////////////////////////////////////////////
  // Run length tracker, avoids long repetitions
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= LPS_S_LOWC;
      run_q  <= 16'h0;
    end else begin
      prev_q <= state;
      run_q  <= (state == prev_q) ? run_q + 16'h1 : 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ovc_gate_off: assert property (state == LPS_S_ACT && faults.overcurrent && quiet
    |=> state == LPS_S_STOP && !ctrl.gate_enable) else $error("gate left on");
  a_stop_len: assert property (state == LPS_S_ACT && prev_q == LPS_S_STOP
    |-> run_q == OVC_CYC + 1 || run_q == REC_CYC + 1) else $error("stop length off");
  a_surge_halt: assert property (faults.surge_high && !faults.ctrl_low
    |=> !ctrl.gate_enable) else $error("switching during surge");
  a_surge_no_soft: assert property (state == LPS_S_SOFT
    |-> prev_q != LPS_S_SURGE) else $error("short surge restarted");
  a_surge_stays: assert property (state == LPS_S_LOWC && faults.surge_high
    && $past(state) == LPS_S_SURGE |=> state == LPS_S_LOWC) else $error("left low power");
  a_ss_len: assert property (state == LPS_S_ACT && prev_q == LPS_S_SOFT
    |-> run_q == SS_CYC + 1) else $error("soft-start length off");
  a_soft_mask: assert property (state == LPS_S_SOFT && quiet && !faults.overcurrent
    |=> state inside {LPS_S_SOFT, LPS_S_ACT}) else $error("soft-start not masked");
  a_lowc_hv: assert property (ctrl.hv_startup_on == (state == LPS_S_LOWC))
    else $error("startup source wrong");
  a_lowc_disch: assert property ($rose(state == LPS_S_LOWC) |-> ctrl.ss_discharge)
    else $error("no discharge");
  a_ctrl_low_now: assert property (faults.ctrl_low |=> state == LPS_S_LOWC)
    else $error("control low ignored");
  a_oov_sink: assert property (state == LPS_S_ACT
    |-> ctrl.fb_extra_sink == $past(faults.out_overvolt)) else $error("sink wrong");
  c_stop_exit: cover property (state == LPS_S_ACT && prev_q == LPS_S_STOP);
  c_surge_long: cover property (state == LPS_S_LOWC && prev_q == LPS_S_SURGE);
  c_soft_done: cover property (state == LPS_S_ACT && prev_q == LPS_S_SOFT);
endmodule : lps_seq_asserts

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import lps_pkg::*;
;
  localparam int OVC = 4, SRG = 8, BRN = 6, OPT = 6, DIS = 5, REC = 10, SS = 6;
  logic        sys_clk     = 1'b0;
  logic        resetn      = 1'b0;
  lps_faults_t req         = '0; // Requested sensor levels
  lps_faults_t faults;
  lps_ctrl_t   ctrl;
  lps_state_t  state;
  int          err_total   = 0;
  int          check_count = 0;
  int          n;                // Edges waited
  lps_sense_model lps_sense_model_i (.req(req), .faults(faults));
  lps_sequencer #(.OVC_CYC(OVC), .SURGE_CYC(SRG), .BRN_CYC(BRN), .OPT_CYC(OPT), .DIS_CYC(DIS),
    .REC_CYC(REC), .SS_CYC(SS)) lps_sequencer_i (.sys_clk(sys_clk), .resetn(resetn),
    .faults(faults), .ctrl(ctrl), .state(state));
  initial forever #4 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      err_total++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Apply levels, then wait bounded for a state
  task automatic go(input logic [7:0] f, input lps_state_t s, input int lim);
    @(negedge sys_clk);
    req = lps_faults_t'(f);
    n   = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (state !== s && n < lim);
    chk(s, state);
    if (state !== s) wrap_up;
  endtask : go
  ////////////////////////////////////////////////////////////
  task automatic t_base;
    go(8'h00, LPS_S_SOFT, 8);
    chk(1'b1, ctrl.soft_start_run);
    go(8'h00, LPS_S_ACT, 20);
    chk(SS + 1, n);
    chk(1'b0, ctrl.hv_startup_on);
    go(8'h80, LPS_S_STOP, 2);
    chk(1'b0, ctrl.gate_enable);
    go(8'h00, LPS_S_ACT, 20);
    chk(OVC + 1, n);
    go(8'h10, LPS_S_STOP, BRN + 3);
    go(8'h00, LPS_S_ACT, 20);
    chk(REC + 1, n);
    go(8'h04, LPS_S_ACT, 2);
    chk(1'b1, ctrl.fb_extra_sink);
    $display("base sequence done");
  endtask : t_base
  task automatic t_surge;
    go(8'h40, LPS_S_SURGE, 2);
    chk(1'b0, ctrl.gate_enable);
    go(8'h00, LPS_S_ACT, 3);
    chk(1, n);
    go(8'h40, LPS_S_LOWC, SRG + 3);
    repeat (6) @(posedge sys_clk);
    #1;
    chk(LPS_S_LOWC, state);
    go(8'h20, LPS_S_SOFT, 3);
    go(8'h00, LPS_S_ACT, 20);
    $display("surge done");
  endtask : t_surge
  task automatic t_lowc;
    go(8'h08, LPS_S_LOWC, OPT + 3);
    chk(1'b1, ctrl.ss_discharge);
    go(8'h00, LPS_S_SOFT, 20);
    chk(REC + 1, n);
    go(8'h08, LPS_S_ACT, 20);
    chk(SS + 1, n);
    go(8'h82, LPS_S_LOWC, 2);
    chk(1, n);
    go(8'h00, LPS_S_SOFT, 3);
    go(8'h00, LPS_S_ACT, 20);
    go(8'h01, LPS_S_LOWC, DIS + 3);
    go(8'h00, LPS_S_SOFT, 20);
    chk(REC + 1, n);
    $display("low power done");
  endtask : t_lowc
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    t_base;
    t_surge;
    t_lowc;
    wrap_up;
  end
endmodule : testbench
bind lps_sequencer lps_seq_asserts #(.OVC_CYC(OVC_CYC), .REC_CYC(REC_CYC), .SS_CYC(SS_CYC))
  lps_seq_asserts_i (.sys_clk(sys_clk), .resetn(resetn), .faults(faults), .ctrl(ctrl), .state(state));
